// ### src/bls_pkg.sv
// constants, types and field layouts of the bitstream loader and start-up block
// assumes a 100 MHz core clock; shared by the loader and its byte buffer
package bls_pkg;

   // core clock and master-mode configuration clock periods
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned SLOW_PERIOD_NS = 1000;   // slow mode, 1 MHz
   localparam int unsigned FAST_PERIOD_NS = 200;    // fast mode, 5 MHz
   localparam int unsigned SLOW_HALF_CYC  = SLOW_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int unsigned FAST_HALF_CYC  = FAST_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int unsigned DIV_W          = 6;      // divider counter width

   // header and trailer fields
   localparam int unsigned FILL_ONES  = 8;          // leading ones
   localparam int unsigned PRE_W      = 4;
   localparam logic [3:0]  PRE_CODE   = 4'h2;       // preamble 0010
   localparam int unsigned LEN_W      = 24;         // length count width
   localparam int unsigned SEP_W      = 4;
   localparam logic [3:0]  SEP_CODE   = 4'hf;       // separator 1111
   localparam int unsigned PART_W     = 4;          // per-frame check width
   localparam int unsigned LAST_W     = 11;         // final frame CRC width
   localparam logic [3:0]  EOF_CODE   = 4'h6;       // non-CRC end of frame 0110
   localparam int unsigned POST_W     = 7;
   localparam logic [6:0]  POST_CODE  = 7'h3f;      // postamble 0111111
   localparam int unsigned FLD_W      = 11;         // field collector width
   localparam int unsigned CNT_W      = 16;         // field bit counter width
   localparam int unsigned BYTE_W     = 8;

   // start-up shift register stages
   localparam int unsigned STG_N      = 5;
   localparam int unsigned STG_FIRST  = 0;          // start-up begins
   localparam int unsigned STG_DONE   = 1;          // completion released
   localparam int unsigned STG_IO     = 2;          // user I/Os active
   localparam int unsigned STG_GSR    = 3;          // global set/reset ends
   localparam int unsigned STG_FIN    = 4;          // sequence finished

   // start-up clocking options
   typedef enum logic [1:0] {
      cfg_clock_free_run,
      cfg_clock_wait_complete,
      user_clock_free_run,
      user_clock_wait_complete
   } bls_su_mode_t;

   // stream parser states
   typedef enum logic [3:0] {
      ST_HUNT, ST_PRE, ST_LEN, ST_SEP, ST_START,
      ST_DATA, ST_CHECK, ST_POST, ST_FULL, ST_ERR
   } bls_state_t;

   // pins arriving from outside the clock domain
   typedef struct packed {
      logic prog_n;   // reconfiguration request, low active
      logic data;     // serial data
      logic config_clock;     // configuration clock from outside
      logic uclk;     // user start-up clock
      logic init;     // configuration-ready line level
      logic done;     // completion line level
   } bls_pins_t;

   localparam bls_pins_t PINS_RST = '{prog_n: 1'b1, data: 1'b1, config_clock: 1'b0,
                                      uclk: 1'b0, init: 1'b0, done: 1'b0};

   // block status
   typedef struct packed {
      logic mem_full;         // all data loaded
      logic error;            // check failed, loading suspended
      logic io_active;        // user I/Os enabled
      logic global_set_reset; // global set/reset still held
   } bls_status_t;

endpackage : bls_pkg

// ### src/bls_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes both sides run on clk; ce freezes all state
`timescale 1ns/1ps
`default_nettype none
module bls_buf2
   import bls_pkg::*;
#(
   parameter int unsigned WIDTH = BYTE_W,  // word width
   parameter int unsigned DEPTH = 2        // entries, fixed structure
) (
   input  wire logic             clk,       // core clock
   input  wire logic             rst_n,     // sync reset, low active
   input  wire logic             ce,        // clock enable
   input  wire logic             clr,       // sync flush
   input  wire logic             in_valid,  // source offers word
   output logic                  in_ready,  // room for a word
   input  wire logic [WIDTH-1:0] in_data,   // offered word
   output logic                  out_valid, // word available
   input  wire logic             out_ready, // sink takes word
   output logic [WIDTH-1:0]      out_data   // oldest word
);

   // refuse shapes the pointer logic cannot serve
   if (DEPTH != 2 || WIDTH < 1) begin : g_chk
      $error("bls_buf2 supports exactly two entries");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];   // storage
   logic             wp_q;            // write pointer
   logic             rp_q;            // read pointer
   logic [1:0]       cnt_q;           // fill level

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rp_q];

   // pointers and level
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && clr)) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else if (ce) begin
         if (in_valid && in_ready) begin
            wp_q <= ~wp_q;
         end
         if (out_valid && out_ready) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
      end
   end

   // storage write
   always_ff @(posedge clk) begin
      if (ce && in_valid && in_ready) begin
         mem_q[wp_q] <= in_data;
      end
   end

endmodule : bls_buf2
`default_nettype wire

// ### src/bls_loader.sv
// configuration bitstream loader with start-up sequencer
// assumes clk at 100 MHz; pins are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
module bls_loader
   import bls_pkg::*;
#(
   parameter int unsigned FRAME_BITS = 64,       // data bits per frame
   parameter int unsigned N_FRAMES   = 4,        // frames per device
   parameter int unsigned CRC_W      = 16,       // running CRC width
   parameter logic [15:0] CRC_POLY   = 16'h8005, // CRC polynomial
   parameter int unsigned ADDR_W     = 18        // memory address width
) (
   input  wire logic                  clk,           // core clock
   input  wire logic                  rst_n,         // sync reset, low
   input  wire logic                  ce,            // clock enable
   input  wire logic                  prog_n_pin,    // restart request pin
   input  wire logic                  master_mode,   // we drive config_clock
   input  wire logic                  byte_mode,     // byte-wide data
   input  wire logic                  fast_clock,    // fast master clock
   input  wire logic                  crc_sel,       // CRC checking
   input  wire bls_su_mode_t          su_mode,       // start-up clocking
   input  wire logic                  config_clock_in,  // clock pin level
   output logic                       config_clock_o,   // clock pin drive
   output logic                       config_clock_oe,  // clock pin enable
   input  wire logic                  data_pin,      // serial data pin
   input  wire logic                  byte_valid,    // byte offered
   output logic                       byte_ready,    // byte accepted
   input  wire logic [BYTE_W-1:0]     byte_data,     // byte, D0 first
   output logic [ADDR_W-1:0]          mem_addr,      // memory address
   input  wire logic                  init_in,       // ready line level
   output logic                       init_o,        // ready line drive
   output logic                       init_oe,       // ready line pull
   input  wire logic                  done_in,       // completion level
   output logic                       done_o,        // completion drive
   output logic                       done_oe,       // completion pull
   input  wire logic                  user_clk_pin,  // user start-up clock
   output logic                       frame_valid,   // frame pulse
   output logic [FRAME_BITS-1:0]      frame_data,    // checked frame
   output logic [CNT_W-1:0]           frame_index,   // frame number
   output logic [LEN_W-1:0]           length_count,  // loaded length
   output bls_status_t                status         // block status
);

   // refuse parameters the logic cannot serve
   if (FRAME_BITS < 8 || FRAME_BITS >= 2**CNT_W || N_FRAMES < 1 ||
       N_FRAMES >= 2**CNT_W || CRC_W < LAST_W || CRC_W > 16) begin : g_chk
      $error("bls_loader parameter out of range");
   end

   // one CRC step per data bit
   function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                 input logic b);
      logic fb;
      fb = c[CRC_W-1] ^ b;
      crc_step = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY[CRC_W-1:0] : '0);
   endfunction : crc_step

   // rising edge of a synchronised level
   function automatic logic rise(input logic now, input logic prev);
      rise = now & ~prev;
   endfunction : rise

   bls_pins_t              s1_q;        // first sync stage
   bls_pins_t              s2_q;        // second sync stage
   bls_pins_t              s3_q;        // edge history
   logic                   restart;     // reconfiguration requested
   logic [DIV_W-1:0]       div_q;       // master clock divider
   logic                   config_clock_q;      // master clock level
   logic                   tick;        // config clock rising edge
   logic                   utick;       // user clock rising edge
   logic                   su_tick;     // selected start-up clock edge
   logic                   bv;          // buffered byte valid
   logic                   brdy;        // buffer drain
   logic [BYTE_W-1:0]      bd;          // buffered byte
   logic [BYTE_W-1:0]      cur_q;       // byte being serialised
   logic                   cur_v_q;     // byte present
   logic [2:0]             bidx_q;      // bit within byte
   logic                   bit_en;      // one stream bit this cycle
   logic                   b;           // the stream bit
   bls_state_t             st_q;        // parser state
   logic [CNT_W-1:0]       cnt_q;       // bits within field
   logic [3:0]             ones_q;      // leading ones seen
   logic [FLD_W-1:0]       fld_q;       // field collector
   logic [FLD_W-1:0]       fld_n;       // collector with this bit
   logic [LEN_W-1:0]       len_q;       // length count
   logic [LEN_W-1:0]       ccnt_q;      // config clocks since ready
   logic [CRC_W-1:0]       crc_q;       // running CRC
   logic [FRAME_BITS-1:0]  fsh_q;       // frame shift register
   logic [CNT_W-1:0]       fidx_q;      // frame counter
   logic                   last_fr;     // final frame of device
   logic [CNT_W-1:0]       chk_len;     // check field width
   logic                   chk_ok;      // check field matches
   logic [STG_N-1:0]       stg_q;       // start-up shift register
   logic                   fval_q;      // frame pulse register
   logic [FRAME_BITS-1:0]  fdat_q;      // frame output register
   logic [ADDR_W-1:0]      addr_q;      // address register
   logic                   user_su;     // user clock steps start-up
   logic                   wait_su;     // wait for completion high

   // pins pass two flops before use
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= PINS_RST;
         s2_q <= PINS_RST;
         s3_q <= PINS_RST;
      end else if (ce) begin
         s1_q <= '{prog_n: prog_n_pin, data: data_pin, config_clock: config_clock_in,
                   uclk: user_clk_pin, init: init_in, done: done_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign restart = ~s2_q.prog_n;

   // master clock divider, runs even after an error
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_q  <= '0;
         config_clock_q <= 1'b0;
      end else if (ce) begin
         if (div_q == DIV_W'(fast_clock ? FAST_HALF_CYC - 1 : SLOW_HALF_CYC - 1)) begin
            div_q  <= '0;
            config_clock_q <= ~config_clock_q;
         end else begin
            div_q <= div_q + 1'b1;
         end
      end
   end

   assign config_clock_o  = config_clock_q;
   assign config_clock_oe = master_mode;

   // config clock edge from our divider or the pin
   always_comb begin
      if (master_mode) begin
         tick = ce && !config_clock_q && div_q == DIV_W'(fast_clock ? FAST_HALF_CYC - 1
                                                           : SLOW_HALF_CYC - 1);
      end else begin
         tick = ce && rise(s2_q.config_clock, s3_q.config_clock);
      end
   end

   assign utick   = ce && rise(s2_q.uclk, s3_q.uclk);
   assign user_su = (su_mode == user_clock_free_run) ||
                    (su_mode == user_clock_wait_complete);
   assign wait_su = (su_mode == cfg_clock_wait_complete) ||
                    (su_mode == user_clock_wait_complete);
   assign su_tick = user_su ? utick : tick;

   // byte path buffer; its ready reaches the source
   bls_buf2 #(
      .WIDTH (BYTE_W),
      .DEPTH (2)
   ) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .clr       (restart),
      .in_valid  (byte_valid && byte_mode),
      .in_ready  (byte_ready),
      .in_data   (byte_data),
      .out_valid (bv),
      .out_ready (brdy),
      .out_data  (bd)
   );

   assign brdy = !cur_v_q && !restart;

   // one bit per config clock; byte mode stalls without a byte
   assign bit_en = tick && !restart && s2_q.init &&
                   (byte_mode ? cur_v_q : 1'b1);
   assign b      = byte_mode ? cur_q[bidx_q] : s2_q.data;

   // byte serialiser, D0 goes first
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         cur_q   <= '0;
         cur_v_q <= 1'b0;
         bidx_q  <= '0;
      end else if (ce) begin
         if (brdy && bv) begin
            cur_q   <= bd;
            cur_v_q <= 1'b1;
            bidx_q  <= '0;
         end else if (bit_en && byte_mode) begin
            bidx_q <= bidx_q + 1'b1;
            if (bidx_q == 3'h7) begin
               cur_v_q <= 1'b0;
            end
         end
      end
   end

   // memory address steps per byte in master byte mode, errors do not stop it
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         addr_q <= '0;
      end else if (ce && master_mode && byte_mode && brdy && bv) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   assign mem_addr = addr_q;

   // check field helpers
   assign fld_n   = {fld_q[FLD_W-2:0], b};
   assign last_fr = (fidx_q == CNT_W'(N_FRAMES - 1));
   assign chk_len = (crc_sel && last_fr) ? CNT_W'(LAST_W) : CNT_W'(PART_W);

   always_comb begin
      if (!crc_sel) begin
         chk_ok = (fld_n[PART_W-1:0] == EOF_CODE);
      end else if (last_fr) begin
         chk_ok = (fld_n[LAST_W-1:0] == crc_q[LAST_W-1:0]);
      end else begin
         chk_ok = (fld_n[PART_W-1:0] == crc_q[PART_W-1:0]);
      end
   end

   // stream parser
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         st_q   <= ST_HUNT;
         cnt_q  <= '0;
         ones_q <= '0;
         fld_q  <= '0;
         len_q  <= '0;
         fidx_q <= '0;
      end else if (bit_en) begin
         fld_q <= fld_n;
         cnt_q <= cnt_q + 1'b1;
         case (st_q)
            // leading ones, then the preamble's first zero
            ST_HUNT: begin
               if (b) begin
                  if (ones_q != 4'(FILL_ONES)) begin
                     ones_q <= ones_q + 1'b1;
                  end
               end else if (ones_q == 4'(FILL_ONES)) begin
                  st_q  <= ST_PRE;
                  cnt_q <= CNT_W'(1);
               end else begin
                  ones_q <= '0;
               end
            end
            // rest of the preamble
            ST_PRE: begin
               if (cnt_q == CNT_W'(PRE_W - 1)) begin
                  cnt_q <= '0;
                  st_q  <= (fld_n[PRE_W-1:0] == PRE_CODE) ? ST_LEN : ST_ERR;
               end
            end
            // length count, most significant bit first
            ST_LEN: begin
               len_q <= {len_q[LEN_W-2:0], b};
               if (cnt_q == CNT_W'(LEN_W - 1)) begin
                  cnt_q <= '0;
                  st_q  <= ST_SEP;
               end
            end
            // separator ahead of the frames
            ST_SEP: begin
               if (cnt_q == CNT_W'(SEP_W - 1)) begin
                  cnt_q <= '0;
                  st_q  <= (fld_n[SEP_W-1:0] == SEP_CODE) ? ST_START : ST_ERR;
               end
            end
            // start field is a single zero
            ST_START: begin
               cnt_q <= '0;
               st_q  <= b ? ST_ERR : ST_DATA;
            end
            // frame data
            ST_DATA: begin
               if (cnt_q == CNT_W'(FRAME_BITS - 1)) begin
                  cnt_q <= '0;
                  st_q  <= ST_CHECK;
               end
            end
            // trailing check field
            ST_CHECK: begin
               if (cnt_q == chk_len - 1'b1) begin
                  cnt_q <= '0;
                  if (!chk_ok) begin
                     st_q <= ST_ERR;
                  end else if (last_fr) begin
                     st_q <= ST_POST;
                  end else begin
                     st_q   <= ST_START;
                     fidx_q <= fidx_q + 1'b1;
                  end
               end
            end
            // postamble closes this device's data
            ST_POST: begin
               if (cnt_q == CNT_W'(POST_W - 1)) begin
                  st_q <= (fld_n[POST_W-1:0] == POST_CODE) ? ST_FULL : ST_ERR;
               end
            end
            // trailing start-up bytes are ignored
            ST_FULL: begin
               cnt_q <= '0;
            end
            // loading suspended until restart
            ST_ERR: begin
               cnt_q <= '0;
            end
            default: begin
               st_q <= ST_ERR;
            end
         endcase
      end
   end

   // running CRC over frame data, kept across frames
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         crc_q <= '0;
      end else if (bit_en && st_q == ST_DATA) begin
         crc_q <= crc_step(crc_q, b);
      end
   end

   // frame shift register and checked frame output
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         fsh_q  <= '0;
         fdat_q <= '0;
         fval_q <= 1'b0;
      end else if (ce) begin
         fval_q <= 1'b0;
         if (bit_en && st_q == ST_DATA) begin
            fsh_q <= {fsh_q[FRAME_BITS-2:0], b};
         end
         if (bit_en && st_q == ST_CHECK && cnt_q == chk_len - 1'b1 && chk_ok) begin
            fdat_q <= fsh_q;
            fval_q <= 1'b1;
         end
      end
   end

   assign frame_valid  = fval_q;
   assign frame_data   = fdat_q;
   assign frame_index  = fidx_q;
   assign length_count = len_q;

   // config clocks counted once the ready line reads high
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         ccnt_q <= '0;
      end else if (tick && s2_q.init && st_q != ST_ERR && !stg_q[STG_FIRST]) begin
         ccnt_q <= ccnt_q + 1'b1;
      end
   end

   // start-up shift register
   always_ff @(posedge clk) begin
      if (!rst_n || (ce && restart)) begin
         stg_q <= '0;
      end else if (ce) begin
         if (tick && st_q == ST_FULL && ccnt_q == len_q) begin
            stg_q[STG_FIRST] <= 1'b1;
         end
         if (tick && stg_q[STG_FIRST]) begin
            stg_q[STG_DONE] <= 1'b1;
         end
         if (su_tick && stg_q[STG_DONE] && (!wait_su || s2_q.done)) begin
            stg_q[STG_IO] <= 1'b1;
         end
         if (su_tick && stg_q[STG_IO]) begin
            stg_q[STG_GSR] <= 1'b1;
         end
         if (su_tick && stg_q[STG_GSR]) begin
            stg_q[STG_FIN] <= 1'b1;
         end
      end
   end

   // open-drain lines only ever pull low
   assign init_o  = 1'b0;
   assign init_oe = (st_q == ST_ERR) || restart;
   assign done_o  = 1'b0;
   assign done_oe = !stg_q[STG_DONE];

   // status outputs
   assign status = '{mem_full:         (st_q == ST_FULL),
                     error:            (st_q == ST_ERR),
                     io_active:        stg_q[STG_IO],
                     global_set_reset: !stg_q[STG_GSR]};

endmodule : bls_loader
`default_nettype wire

// ### tb/bls_loader_monitor.sv
// port checker for the loader
// assumes the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module bls_loader_monitor
   import bls_pkg::*;
(
   input wire logic        clk,             // core clock
   input wire logic        rst_n,           // sync reset
   input wire logic        prog_n_pin,      // restart pin
   input wire logic        master_mode,     // clock drive mode
   input wire logic        config_clock_oe, // clock pin enable
   input wire logic        init_oe,         // ready pull
   input wire logic        done_oe,         // done pull
   input wire logic        frame_valid,     // frame pulse
   input wire bls_status_t status           // flags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_clock_pin_mode:
   assert property (config_clock_oe == master_mode) else $error("clock enable");
   chk_frame_pulse_once:
   assert property (frame_valid |=> !frame_valid) else $error("long pulse");
   chk_error_pulls_ready:
   assert property (status.error |-> init_oe && !frame_valid) else $error("error hidden");
   chk_error_stays_set:
   assert property (prog_n_pin [*4] ##0 status.error |=> status.error) else $error("error lost");
   chk_restart_pulls_ready:
   assert property (!prog_n_pin [*4] |-> init_oe) else $error("ready free");
   chk_done_before_io:
   assert property (status.io_active |-> !done_oe && status.mem_full) else $error("io early");
   chk_io_before_reset:
   assert property (!status.global_set_reset |-> status.io_active) else $error("reset early");
   chk_reset_after_io:
   assert property ($rose(status.io_active) |-> status.global_set_reset [*2]) else $error("gsr");
endmodule : bls_loader_monitor
bind bls_loader bls_loader_monitor u_bls_loader_monitor (.clk, .rst_n, .prog_n_pin,
   .master_mode, .config_clock_oe, .init_oe, .done_oe, .frame_valid, .status);
`default_nettype wire

// ### tb/bls_src_model.sv
// serial source: one 80 ns clock per queued bit
// assumes the bench fills the bit queue
`timescale 1ns/1ps
`default_nettype none
module bls_src_model (
   output logic config_clock, // config clock
   output logic dat   // serial data
);
   logic q[$]; // bits to send
   // clock stands still when idle
   initial begin
      config_clock = 0;
      dat = 1;
      forever begin
         wait (q.size() > 0);
         #3; // step off the core clock edge
         while (q.size() > 0) begin
            dat = q.pop_front();
            #40 config_clock = 1;
            #40 config_clock = 0;
         end
         dat = ~dat; // last bit inverted once the queue empties
      end
   end
endmodule : bls_src_model
`default_nettype wire

// ### tb/bls_loader_tb_top.sv
// bench: clean serial loads with and without CRC, then one with a bad check
// assumes the source model makes clock and data
`timescale 1ns/1ps
`default_nettype none
module bls_loader_tb_top;
   import bls_pkg::*;
   logic clk, rst_n = 0, prog_n_pin = 1, fast_clock = 0, user_clk_pin = 0;
   logic ce = 1, crc_sel = 0;
   logic config_clock_in, data_pin, init_oe, done_oe, frame_valid;
   logic [7:0] byte_data = 0, frame_data;
   logic [23:0] length_count;
   bls_status_t status;
   bls_su_mode_t su_mode = user_clock_wait_complete;
   logic [63:0] exp_q[$]; // expected frames
   int errors = 0, checks = 0, i;
   bls_loader #(.FRAME_BITS(8), .N_FRAMES(2)) u_bls_loader (.clk, .rst_n, .ce, .prog_n_pin,
      .master_mode(1'b0), .byte_mode(1'b0), .fast_clock, .crc_sel, .su_mode,
      .config_clock_in, .config_clock_o(), .config_clock_oe(), .data_pin, .byte_valid(1'b0),
      .byte_ready(), .byte_data, .mem_addr(), .init_in(!init_oe), .init_o(), .init_oe,
      .done_in(!done_oe), .done_o(), .done_oe, .user_clk_pin, .frame_valid, .frame_data,
      .frame_index(), .length_count, .status);
   bls_src_model u_bls_src_model (.config_clock(config_clock_in), .dat(data_pin));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always #30 user_clk_pin = ~user_clk_pin; // free user clock
   task automatic chk(input string nm, input logic [63:0] s, e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic summarize;
      if (errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic put(input logic [31:0] v, input int n);
      for (int k = n - 1; k >= 0; k--) u_bls_src_model.q.push_back(v[k]);
   endtask : put
   // header, two frames, postamble, spare clocks
   task automatic load(input logic bad, crc);
      logic [7:0] d;
      logic [15:0] c; // running check over data bits
      c = '0;
      put({8'hff, PRE_CODE}, 12);
      put({crc ? 24'd84 : 24'd76, SEP_CODE}, 28);
      for (int f = 0; f < 2; f++) begin
         d = 8'($urandom);
         for (int k = 7; k >= 0; k--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h8005 : 16'h0);
         put({1'b0, d}, 9);
         if (crc) put(f ? c[10:0] : c[3:0], f ? 11 : 4);
         else put((bad && f) ? 4'h9 : EOF_CODE, 4);
         if (!(bad && f)) exp_q.push_back(64'(d));
      end
      put({POST_CODE, 16'hffff}, 23);
   endtask : load
   task automatic wt(input logic err);
      for (i = 0; i < 3000 && (err ? status.error : !status.global_set_reset) !== 1'b1; i++)
         @(negedge clk);
      if (i == 3000) begin
         errors++;
         summarize();
      end
   endtask : wt
   // frame watcher
   always @(negedge clk)
      if (frame_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("frame count", 1, 0);
         else chk("frame", 64'(frame_data), exp_q.pop_front());
      end
   initial begin
      void'($urandom(32'haf8d));
      repeat (5) @(posedge clk);
      rst_n <= 1;
      fast_clock <= 1'($urandom);
      byte_data <= 8'($urandom);
      repeat (4) @(posedge clk);
      for (int s = 0; s < 3; s++) begin
         if (s > 0) begin
            repeat (120) @(posedge clk); // let the spare clocks drain
            prog_n_pin <= 0;
            su_mode <= cfg_clock_free_run;
            crc_sel <= (s == 1);
            repeat (6) @(posedge clk);
            prog_n_pin <= 1;
            repeat (6) @(posedge clk);
         end
         load(s == 2, s == 1);
         if (s == 1) begin
            repeat (60) @(posedge clk); // freeze across a clock rise
            ce <= 0;
            repeat (2) @(posedge clk);
            ce <= 1;
         end
         wt(s == 2);
         if (s < 2) begin
            chk("status", 64'(status), 64'ha);
            chk("length", 64'(length_count), s ? 64'd84 : 64'd76);
         end
      end
      chk("ready pull", 64'(init_oe), 64'h1);
      chk("status", 64'(status), 64'h5);
      chk("frames left", 64'(exp_q.size()), 64'h0);
      summarize();
   end
endmodule : bls_loader_tb_top
`default_nettype wire
